// ### logic/lacc_top.sv
// Purpose: Limit-value process alarms and host command checking for two weighing channels.
// Assumes: Single AHB-Lite slave on the bus; limit and fault levels arrive asynchronously.
// Notes:   Writes finish with no wait state, reads with one.
// Summary of operation
// - Any limit change on either channel raises a process alarm; steady limits raise none.
// - Channel 1 alarm bits: 0 limit1 comes, 1 goes, 2 limit2 comes, 3 goes.
// - Channel 2 alarm bits: 4 limit1 comes, 5 goes, 6 limit2 comes, 7 goes.
// - Adjustment points lying too close together reject the command with code 0.
// - While a fault is present every command is refused with code 1.
// - Missing or inactive channel addressed gives code 2.
// - Undefined parameter or command code gives code 3.
// - Unknown data record number gives code 4.
// - Command needing a calibrated scale on an unadjusted scale gives code 5.
// - A negative adjustment weight is rejected with code 7.
`timescale 1ns/10ps
module lacc_top #(
  parameter int          ADJ_WAIT_CYC = lacc_pkg::ADJ_WAIT_CYCLES,
  parameter logic [31:0] MIN_SPAN     = lacc_pkg::MIN_SPAN_DEF,
  parameter logic [3:0]  FILT_MAX     = lacc_pkg::FILT_MAX_DEF
) (
  // Clock and reset.
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  // AHB-Lite slave.
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  // Process side.
  input  wire logic [3:0]  LIMIT,
  input  wire logic        FAULT,
  output logic [7:0]       ALARM_BYTE,
  output logic             ALARM_STROBE,
  output logic             IRQ
);
  localparam int WAIT_W = lacc_pkg::WAIT_W;
  // Loaded one short, so a command exactly ADJ_WAIT_CYC cycles after the last one is accepted.
  localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(ADJ_WAIT_CYC - 1);

  typedef struct packed {
    logic [3:0]             lim_s1;
    logic [3:0]             lim_s2;
    logic [3:0]             lim_prev;
    logic                   flt_s1;
    logic                   flt_s2;
    logic [7:0]             alarm;
    logic                   alarm_stb;
    logic [1:0]             ch_act;
    logic [2:0]             irq_st;
    logic [2:0]             irq_mask;
    logic [31:0]            cmd_data;
    logic [3:0]             res_code;
    logic                   res_rej;
    logic                   res_acc;
    logic [31:0]            rdata;
    logic [1:0][31:0]       zero;
    logic [1:0][31:0]       adj_wt;
    logic [1:0][31:0]       wdig;
    logic [1:0]             zero_def;
    logic [1:0]             wt_def;
    logic [1:0]             wdig_def;
    logic [1:0][3:0]        filt;
    logic [1:0]             weighing;
    logic [WAIT_W-1:0]      wait_cnt;
    logic                   wr_pend;
    logic                   rd_pend;
    logic [7:0]             addr;
    logic [31:0]            hrdata;
  } lacc_state_t;

  lacc_state_t st;
  lacc_state_t next_st;

  logic        accept;
  logic        cmd_go;
  logic [2:0]  cmd_op;
  logic [1:0]  cmd_ch;
  logic [7:0]  cmd_rec;
  logic        ci;
  logic [3:0]  change;
  logic        chk_err;
  logic [3:0]  chk_code;
  logic [31:0] rd_val;
  logic [2:0]  irq_clr;
  logic [2:0]  irq_set;
  logic [1:0]  adj_now;
  logic        cmd_chk_ok;

  // Calibration is complete only when all three adjustment values exist.
  function automatic logic [1:0] adjusted(input lacc_state_t s);
    adjusted = s.zero_def & s.wt_def & s.wdig_def;
  endfunction

  // Comes in the even bit, goes in the odd bit, channel 1 in the low nibble.
  function automatic logic [7:0] alarm_bits(input logic [3:0] cur, input logic [3:0] prev);
    alarm_bits = '0;
    for (int i = 0; i < lacc_pkg::NUM_LIM; i++) begin
      alarm_bits[2*i]   = cur[i] & ~prev[i];
      alarm_bits[2*i+1] = ~cur[i] & prev[i];
    end
  endfunction

  assign accept    = HSEL && HREADY && (HTRANS == lacc_pkg::HTRANS_NONSEQ || HTRANS == lacc_pkg::HTRANS_SEQ);
  assign cmd_go    = st.wr_pend && st.addr == lacc_pkg::OFF_CMD;
  assign cmd_op    = HWDATA[lacc_pkg::CMD_OP_LSB +: 3];
  assign cmd_ch    = HWDATA[lacc_pkg::CMD_CH_LSB +: 2];
  assign cmd_rec   = HWDATA[lacc_pkg::CMD_REC_LSB +: 8];
  assign ci        = cmd_ch[0];
  assign adj_now   = adjusted(st);
  assign cmd_chk_ok = cmd_go && !st.flt_s2 && cmd_ch < lacc_pkg::NUM_CH && st.ch_act[ci];
  assign change    = st.lim_s2 ^ st.lim_prev;
  assign HREADYOUT = !st.rd_pend;
  assign HRDATA    = st.hrdata;
  assign HRESP     = 1'b0;
  assign ALARM_BYTE   = st.alarm;
  assign ALARM_STROBE = st.alarm_stb;
  assign IRQ          = |(st.irq_st & st.irq_mask);

  lacc_check #(
    .MIN_SPAN (MIN_SPAN),
    .FILT_MAX (FILT_MAX)
  ) u_check (
    .op        (cmd_op),
    .chan      (cmd_ch),
    .rec       (cmd_rec),
    .data      (st.cmd_data),
    .fault     (st.flt_s2),
    .ch_act    (st.ch_act),
    .adjusted  (adj_now[ci]),
    .zero_def  (st.zero_def[ci]),
    .wdig_def  (st.wdig_def[ci]),
    .zero      (st.zero[ci]),
    .wdig      (st.wdig[ci]),
    .wait_busy (st.wait_cnt != '0),
    .err       (chk_err),
    .code      (chk_code)
  );

  always_comb begin
    rd_val = '0;
    unique case (st.addr)
      lacc_pkg::OFF_CTRL:     rd_val[1:0] = st.ch_act;
      lacc_pkg::OFF_STATUS: begin
        rd_val[lacc_pkg::ST_ADJ_LSB +: 2]   = adjusted(st);
        rd_val[lacc_pkg::ST_WEIGH_LSB +: 2] = st.weighing;
        rd_val[lacc_pkg::ST_FAULT_BIT]      = st.flt_s2;
        rd_val[lacc_pkg::ST_WAIT_BIT]       = st.wait_cnt != '0;
        rd_val[lacc_pkg::ST_LIM_LSB +: 4]   = st.lim_s2;
      end
      lacc_pkg::OFF_ALARM:    rd_val[7:0] = st.alarm;
      lacc_pkg::OFF_IRQ_STAT: rd_val[2:0] = st.irq_st;
      lacc_pkg::OFF_IRQ_MASK: rd_val[2:0] = st.irq_mask;
      lacc_pkg::OFF_CMD_DATA: rd_val      = st.cmd_data;
      lacc_pkg::OFF_RESULT: begin
        rd_val[lacc_pkg::RES_CODE_LSB +: 4] = st.res_code;
        rd_val[lacc_pkg::RES_REJ_BIT]       = st.res_rej;
        rd_val[lacc_pkg::RES_ACC_BIT]       = st.res_acc;
      end
      lacc_pkg::OFF_RDATA:    rd_val      = st.rdata;
      default:                rd_val      = '0;
    endcase
  end

  always_comb begin
    next_st = st;
    irq_clr = '0;
    irq_set = '0;
    // Both synchroniser chains; only the second stage feeds any logic.
    next_st.lim_s1   = LIMIT;
    next_st.lim_s2   = st.lim_s1;
    next_st.lim_prev = st.lim_s2;
    next_st.flt_s1   = FAULT;
    next_st.flt_s2   = st.flt_s1;
    next_st.alarm_stb = |change;
    if (|change) begin
      next_st.alarm = alarm_bits(st.lim_s2, st.lim_prev);
    end
    irq_set[lacc_pkg::IRQ_ALARM] = |change;
    // Bus pipeline: a read waits one cycle so its data come from a flop.
    next_st.wr_pend = accept && HWRITE;
    next_st.rd_pend = accept && !HWRITE;
    if (accept) begin
      next_st.addr = HADDR[7:0];
    end
    if (st.rd_pend) begin
      next_st.hrdata = rd_val;
    end
    if (st.wait_cnt != '0) begin
      next_st.wait_cnt = st.wait_cnt - 1'b1;
    end
    if (st.wr_pend) begin
      unique case (st.addr)
        lacc_pkg::OFF_CTRL:     next_st.ch_act   = HWDATA[1:0];
        lacc_pkg::OFF_IRQ_STAT: irq_clr          = HWDATA[2:0];
        lacc_pkg::OFF_IRQ_MASK: next_st.irq_mask = HWDATA[2:0];
        lacc_pkg::OFF_CMD_DATA: next_st.cmd_data = HWDATA;
        default: ;
      endcase
    end
    if (cmd_go) begin
      // The verdict is the immediate reply; a rejection commits nothing else.
      next_st.res_code = chk_err ? chk_code : lacc_pkg::ERR_DIST;
      next_st.res_rej  = chk_err;
      next_st.res_acc  = !chk_err;
      irq_set[lacc_pkg::IRQ_REJ] = chk_err;
      irq_set[lacc_pkg::IRQ_ACC] = !chk_err;
      if (!chk_err) begin
        unique case (cmd_op)
          lacc_pkg::OP_WRITE_REC: begin
            if (cmd_rec == lacc_pkg::REC_ADJ_WT) begin
              next_st.adj_wt[ci] = st.cmd_data;
              next_st.wt_def[ci] = 1'b1;
            end else begin
              next_st.filt[ci] = st.cmd_data[3:0];
            end
          end
          lacc_pkg::OP_READ_REC: begin
            unique case (cmd_rec)
              lacc_pkg::REC_ADJ_WT: next_st.rdata = st.adj_wt[ci];
              lacc_pkg::REC_FILTER: next_st.rdata = {28'h0, st.filt[ci]};
              lacc_pkg::REC_ZERO:   next_st.rdata = st.zero[ci];
              default:              next_st.rdata = st.wdig[ci];
            endcase
          end
          lacc_pkg::OP_ADJ_ZERO: begin
            next_st.zero[ci]     = st.cmd_data;
            next_st.zero_def[ci] = 1'b1;
            next_st.wait_cnt     = WAIT_LOAD;
          end
          lacc_pkg::OP_ADJ_WT: begin
            next_st.wdig[ci]     = st.cmd_data;
            next_st.wdig_def[ci] = 1'b1;
            next_st.wait_cnt     = WAIT_LOAD;
          end
          lacc_pkg::OP_START: next_st.weighing[ci] = 1'b1;
          default:            next_st.weighing[ci] = 1'b0;
        endcase
      end
    end
    // A new event outweighs a clear written in the same cycle.
    next_st.irq_st = (st.irq_st & ~irq_clr) | irq_set;
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      st        <= '0;
      st.ch_act <= lacc_pkg::CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  property p_alarm_on_change;
    (st.lim_s2 != st.lim_prev) |=> ALARM_STROBE && st.irq_st[lacc_pkg::IRQ_ALARM];
  endproperty
  a_alarm_on_change: assert property (p_alarm_on_change) else $error("limit change gave no alarm");

  property p_no_alarm_steady;
    (st.lim_s2 == st.lim_prev) |=> !ALARM_STROBE ##0 $stable(ALARM_BYTE);
  endproperty
  a_no_alarm_steady: assert property (p_no_alarm_steady) else $error("alarm without limit change");

  property p_ch1_comes;
    (st.lim_s2[0] && !st.lim_prev[0] && st.lim_s2[1] == st.lim_prev[1]) |=> ALARM_BYTE[3:0] == 4'h1;
  endproperty
  a_ch1_comes: assert property (p_ch1_comes) else $error("channel 1 limit 1 comes bit wrong");

  property p_ch2_goes;
    (!st.lim_s2[3] && st.lim_prev[3] && st.lim_s2[2] == st.lim_prev[2]) |=> ALARM_BYTE[7:4] == 4'h8;
  endproperty
  a_ch2_goes: assert property (p_ch2_goes) else $error("channel 2 limit 2 goes bit wrong");

  property p_fault_refuses;
    (cmd_go && st.flt_s2) |=> st.res_rej && st.res_code == lacc_pkg::ERR_FAULT && HRESP == 1'b0;
  endproperty
  a_fault_refuses: assert property (p_fault_refuses) else $error("command taken during fault");

  property p_bad_channel;
    (cmd_go && !st.flt_s2 && (cmd_ch >= lacc_pkg::NUM_CH || !st.ch_act[ci]))
      |=> st.res_rej && st.res_code == lacc_pkg::ERR_CHAN;
  endproperty
  a_bad_channel: assert property (p_bad_channel) else $error("bad channel not rejected");

  property p_code_range;
    st.res_code <= lacc_pkg::ERR_NEG && (st.res_acc -> st.res_code == lacc_pkg::ERR_DIST);
  endproperty
  a_code_range: assert property (p_code_range) else $error("reserved error code reported");

  property p_reject_keeps;
    (cmd_go && chk_err) |=> $stable(st.zero) && $stable(st.wdig) && $stable(st.adj_wt)
      && $stable(st.filt) && $stable(st.weighing) && $stable(st.rdata) && st.res_rej && !st.res_acc;
  endproperty
  a_reject_keeps: assert property (p_reject_keeps) else $error("rejected command changed state");

  property p_wait_window;
    (cmd_go && !chk_err && (cmd_op == lacc_pkg::OP_ADJ_ZERO || cmd_op == lacc_pkg::OP_ADJ_WT))
      |=> st.wait_cnt == WAIT_LOAD ##1 st.wait_cnt == WAIT_LOAD - 1'b1;
  endproperty
  a_wait_window: assert property (p_wait_window) else $error("adjustment spacing not started");

  property p_unadjusted;
    (cmd_go && !st.flt_s2 && cmd_ch < lacc_pkg::NUM_CH && st.ch_act[ci] && cmd_op == lacc_pkg::OP_START
      && !(st.zero_def[ci] && st.wt_def[ci] && st.wdig_def[ci]))
      |=> st.res_code == lacc_pkg::ERR_UNADJ && !st.weighing[$past(ci)];
  endproperty
  a_unadjusted: assert property (p_unadjusted) else $error("weighing started on unadjusted scale");

  property p_ch1_lim2_goes;
    (!st.lim_s2[1] && st.lim_prev[1] && st.lim_s2[0] == st.lim_prev[0]) |=> ALARM_BYTE[3:0] == 4'h8;
  endproperty
  a_ch1_lim2_goes: assert property (p_ch1_lim2_goes) else $error("channel 1 limit 2 goes bit wrong");

  property p_ch2_lim1_comes;
    (st.lim_s2[2] && !st.lim_prev[2] && st.lim_s2[3] == st.lim_prev[3]) |=> ALARM_BYTE[7:4] == 4'h1;
  endproperty
  a_ch2_lim1_comes: assert property (p_ch2_lim1_comes) else $error("channel 2 limit 1 comes bit wrong");

  property p_undef_op;
    (cmd_chk_ok && cmd_op > lacc_pkg::OP_STOP) |=> st.res_rej && st.res_code == lacc_pkg::ERR_CODE;
  endproperty
  a_undef_op: assert property (p_undef_op) else $error("undefined command not rejected");

  property p_bad_record;
    (cmd_chk_ok && cmd_op == lacc_pkg::OP_READ_REC
      && (cmd_rec < lacc_pkg::REC_ADJ_WT || cmd_rec > lacc_pkg::REC_WDIG))
      |=> st.res_rej && st.res_code == lacc_pkg::ERR_REC;
  endproperty
  a_bad_record: assert property (p_bad_record) else $error("unknown record not rejected");

  property p_wait_refuse;
    (cmd_chk_ok && (cmd_op == lacc_pkg::OP_ADJ_ZERO || cmd_op == lacc_pkg::OP_ADJ_WT) && st.wait_cnt != '0)
      |=> st.res_rej && st.res_code == lacc_pkg::ERR_WAIT;
  endproperty
  a_wait_refuse: assert property (p_wait_refuse) else $error("early adjustment not refused");

  property p_neg_weight;
    (cmd_chk_ok && cmd_op == lacc_pkg::OP_WRITE_REC && cmd_rec == lacc_pkg::REC_ADJ_WT
      && st.cmd_data[lacc_pkg::SIGN_BIT])
      |=> st.res_rej && st.res_code == lacc_pkg::ERR_NEG;
  endproperty
  a_neg_weight: assert property (p_neg_weight) else $error("negative weight not rejected");

  c_alarm:   cover property (ALARM_STROBE && IRQ);
  c_reject:  cover property (st.res_rej && st.res_code == lacc_pkg::ERR_WAIT);
  c_adjust:  cover property (st.res_acc && adjusted(st) != 2'h0);
  c_weigh:   cover property (st.weighing != 2'h0);
endmodule // lacc_top

// ### logic/lacc_pkg.sv
// Purpose: Shared constants for the limit alarm and command check block.
// Assumes: 32-bit AHB-Lite register bus, 200 MHz clock.
// Notes:   Every register takes one aligned word; unmapped reads return zero.
package lacc_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_ALARM    = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_CMD_DATA = 8'h14;
  localparam logic [7:0] OFF_CMD      = 8'h18;
  localparam logic [7:0] OFF_RESULT   = 8'h1C;
  localparam logic [7:0] OFF_RDATA    = 8'h20;
  // Command word fields.
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_CH_LSB  = 4;
  localparam int CMD_REC_LSB = 8;
  localparam int SIGN_BIT    = 31;
  // Result word fields.
  localparam int RES_CODE_LSB = 0;
  localparam int RES_REJ_BIT  = 8;
  localparam int RES_ACC_BIT  = 9;
  // Status word fields.
  localparam int ST_ADJ_LSB   = 0;
  localparam int ST_WEIGH_LSB = 2;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_WAIT_BIT  = 5;
  localparam int ST_LIM_LSB   = 8;
  // Limit inputs: channel 1 limit 1, channel 1 limit 2, channel 2 limit 1, channel 2 limit 2.
  localparam int NUM_LIM = 4;
  // Interrupt status bits.
  localparam int IRQ_W     = 3;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_REJ   = 1;
  localparam int IRQ_ACC   = 2;
  localparam logic [1:0] CTRL_RST = 2'h3;
  // Commands.
  localparam logic [2:0] OP_WRITE_REC = 3'h0;
  localparam logic [2:0] OP_READ_REC  = 3'h1;
  localparam logic [2:0] OP_ADJ_ZERO  = 3'h2;
  localparam logic [2:0] OP_ADJ_WT    = 3'h3;
  localparam logic [2:0] OP_START     = 3'h4;
  localparam logic [2:0] OP_STOP      = 3'h5;
  // Data record numbers.
  localparam logic [7:0] REC_ADJ_WT = 8'h01;
  localparam logic [7:0] REC_FILTER = 8'h02;
  localparam logic [7:0] REC_ZERO   = 8'h03;
  localparam logic [7:0] REC_WDIG   = 8'h04;
  // Data and operator error codes.
  localparam logic [3:0] ERR_DIST  = 4'h0;
  localparam logic [3:0] ERR_FAULT = 4'h1;
  localparam logic [3:0] ERR_CHAN  = 4'h2;
  localparam logic [3:0] ERR_CODE  = 4'h3;
  localparam logic [3:0] ERR_REC   = 4'h4;
  localparam logic [3:0] ERR_UNADJ = 4'h5;
  localparam logic [3:0] ERR_WAIT  = 4'h6;
  localparam logic [3:0] ERR_NEG   = 4'h7;
  localparam logic [1:0] NUM_CH    = 2'h2;
  // AHB transfer types.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  // Spacing of adjustment commands.
  localparam int CLK_HZ          = 200_000_000;
  localparam int ADJ_WAIT_S      = 5;
  localparam int ADJ_WAIT_CYCLES = ADJ_WAIT_S * CLK_HZ;
  localparam int WAIT_W          = 30;
  localparam logic [31:0] MIN_SPAN_DEF = 32'h0000_0100;
  localparam logic [3:0]  FILT_MAX_DEF = 4'h7;
endpackage

// ### logic/lacc_check.sv
// Purpose: Combinational check of one host command against the block state.
// Assumes: Channel fields already selected for the addressed channel.
// Notes:   The first failing test in priority order gives the error code.
`timescale 1ns/10ps
module lacc_check #(
  parameter logic [31:0] MIN_SPAN = lacc_pkg::MIN_SPAN_DEF,
  parameter logic [3:0]  FILT_MAX = lacc_pkg::FILT_MAX_DEF
) (
  // Command.
  input  wire logic [2:0]  op,
  input  wire logic [1:0]  chan,
  input  wire logic [7:0]  rec,
  input  wire logic [31:0] data,
  // Block state.
  input  wire logic        fault,
  input  wire logic [1:0]  ch_act,
  input  wire logic        adjusted,
  input  wire logic        zero_def,
  input  wire logic        wdig_def,
  input  wire logic [31:0] zero,
  input  wire logic [31:0] wdig,
  input  wire logic        wait_busy,
  // Verdict.
  output logic             err,
  output logic [3:0]       code
);
  logic        op_known;
  logic        rec_bad;
  logic [31:0] other;
  logic        other_def;
  logic [32:0] diff;
  logic [32:0] span;

  always_comb begin
    op_known  = op <= lacc_pkg::OP_STOP;
    rec_bad   = (op == lacc_pkg::OP_WRITE_REC && rec != lacc_pkg::REC_ADJ_WT && rec != lacc_pkg::REC_FILTER) ||
                (op == lacc_pkg::OP_READ_REC && (rec < lacc_pkg::REC_ADJ_WT || rec > lacc_pkg::REC_WDIG));
    // Each adjustment point is measured against the other one, if that is defined.
    other     = (op == lacc_pkg::OP_ADJ_ZERO) ? wdig : zero;
    other_def = (op == lacc_pkg::OP_ADJ_ZERO) ? wdig_def : (op == lacc_pkg::OP_ADJ_WT && zero_def);
    diff      = {data[lacc_pkg::SIGN_BIT], data} - {other[lacc_pkg::SIGN_BIT], other};
    span      = diff[32] ? 33'(-diff) : diff;
    err       = 1'b1;
    if (fault) begin
      code = lacc_pkg::ERR_FAULT;
    end else if (chan >= lacc_pkg::NUM_CH || !ch_act[chan[0]]) begin
      code = lacc_pkg::ERR_CHAN;
    end else if (!op_known) begin
      code = lacc_pkg::ERR_CODE;
    end else if (rec_bad) begin
      code = lacc_pkg::ERR_REC;
    end else if (op == lacc_pkg::OP_START && !adjusted) begin
      code = lacc_pkg::ERR_UNADJ;
    end else if ((op == lacc_pkg::OP_ADJ_ZERO || op == lacc_pkg::OP_ADJ_WT) && wait_busy) begin
      code = lacc_pkg::ERR_WAIT;
    end else if (op == lacc_pkg::OP_WRITE_REC && rec == lacc_pkg::REC_ADJ_WT && data[lacc_pkg::SIGN_BIT]) begin
      code = lacc_pkg::ERR_NEG;
    end else if (other_def && span < {1'b0, MIN_SPAN}) begin
      code = lacc_pkg::ERR_DIST;
    end else if (op == lacc_pkg::OP_WRITE_REC && rec == lacc_pkg::REC_FILTER && data > {28'h0, FILT_MAX}) begin
      code = lacc_pkg::ERR_CODE;
    end else begin
      err  = 1'b0;
      code = lacc_pkg::ERR_DIST;
    end
  end
endmodule // lacc_check

// ### test/lacc_host.sv
// Purpose: Host model that masters the register bus for the bench.
// Assumes: One slave whose HREADYOUT is looped back as HREADY.
// Notes:   Every wait is bounded; a slave that never answers sets hung.
`timescale 1ns/10ps
module lacc_host (
  // Clock.
  input  wire logic        CLOCK,
  // AHB-Lite master.
  input  wire logic        HREADY,
  input  wire logic [31:0] HRDATA,
  output logic             HSEL,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [2:0]       HSIZE,
  output logic [31:0]      HWDATA,
  // Status.
  output logic             hung
);
  initial begin
    HSEL = 1'h0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'h0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    hung = 1'h0;
  end

  // Holds everything until HREADY is sampled high at a rising edge, or for at most 16 rising edges.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (HREADY !== 1'b1 && n < 16);
    if (HREADY !== 1'b1) hung = 1'h1;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge CLOCK);
    HSEL <= 1'h1;
    HADDR <= {24'h0, a};
    HTRANS <= lacc_pkg::HTRANS_NONSEQ;
    HWRITE <= w;
    wait_ready();
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_ready();
    r = HRDATA;
  endtask
endmodule // lacc_host

// ### test/lacc_top_tb.sv
// Purpose: Self-checking bench for alarms, interrupts and command checking.
// Assumes: Adjustment spacing shortened to 20 cycles.
// Notes:   Each scenario is its own task and judges its own replies.
`timescale 1ns/10ps
module lacc_top_tb;
  logic        CLOCK;
  logic        RESET_N;
  logic        HSEL;
  logic [31:0] HADDR;
  logic [1:0]  HTRANS;
  logic        HWRITE;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA;
  logic        HREADYOUT;
  logic [31:0] HRDATA;
  logic        HRESP;
  logic [3:0]  LIMIT;
  logic        FAULT;
  logic [7:0]  ALARM_BYTE;
  logic        ALARM_STROBE;
  logic        IRQ;
  logic        hung;
  int          fails;
  int          total_checks;

  lacc_top #(.ADJ_WAIT_CYC(20)) lacc_top_inst (.CLOCK(CLOCK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .LIMIT(LIMIT), .FAULT(FAULT),
    .ALARM_BYTE(ALARM_BYTE), .ALARM_STROBE(ALARM_STROBE), .IRQ(IRQ));
  lacc_host lacc_host_inst (.CLOCK(CLOCK), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .hung(hung));

  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    lacc_host_inst.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] r);
    lacc_host_inst.xfer(1'b0, a, 32'h0, r);
  endtask

  function automatic logic [15:0] cw(logic [2:0] op, logic [1:0] ch, logic [7:0] rec);
    return {rec, 2'h0, ch, 1'h0, op};
  endfunction

  function automatic logic [31:0] rej(logic [3:0] code);
    return {23'h0, 1'h1, 4'h0, code};
  endfunction

  // Sends the operand, launches the command and checks the reply word.
  task automatic cmd(logic [15:0] c, logic [31:0] d, logic [31:0] exp);
    logic [31:0] r;
    wr(lacc_pkg::OFF_CMD_DATA, d);
    wr(lacc_pkg::OFF_CMD, {16'h0, c});
    rd(lacc_pkg::OFF_RESULT, r);
    chk("result", r, exp);
  endtask

  // Waits a bounded time for one alarm strobe.
  task automatic see(output logic got);
    got = 1'b0;
    for (int n = 0; n < 10 && !got; n++) begin
      @(posedge CLOCK);
      #1;
      got = (ALARM_STROBE === 1'b1);
    end
  endtask

  task automatic t_reset();
    logic [31:0] r;
    rd(lacc_pkg::OFF_CTRL, r);
    chk("ctrl", r, 32'h3);
    chk("reset alarm", {24'h0, ALARM_BYTE}, 32'h0);
    chk("reset irq", {31'h0, IRQ}, 32'h0);
    rd(8'h40, r);
    chk("unmapped", r, 32'h0);
    chk("hresp", {31'h0, HRESP}, 32'h0);
  endtask

  task automatic t_alarm();
    logic s;
    wr(lacc_pkg::OFF_IRQ_MASK, 32'h1);
    wr(lacc_pkg::OFF_IRQ_STAT, 32'h7);
    // First pass raises each limit in turn, second pass drops them.
    for (int i = 0; i < 8; i++) begin
      @(posedge CLOCK);
      LIMIT[i % 4] <= (i < 4);
      see(s);
      chk("strobe", {31'h0, s}, 32'h1);
      chk("alarm byte", {24'h0, ALARM_BYTE}, 32'h1 << (2 * (i % 4) + i / 4));
      chk("irq set", {31'h0, IRQ}, 32'h1);
      wr(lacc_pkg::OFF_IRQ_STAT, 32'h1);
      #1;
      chk("irq clear", {31'h0, IRQ}, 32'h0);
    end
    see(s);
    chk("steady", {31'h0, s}, 32'h0);
  endtask

  task automatic t_cmds();
    logic [31:0] r;
    FAULT <= 1'b1;
    repeat (4) @(posedge CLOCK);
    cmd(cw(lacc_pkg::OP_START, 2'h0, 8'h0), 32'h0, rej(lacc_pkg::ERR_FAULT));
    FAULT <= 1'b0;
    repeat (4) @(posedge CLOCK);
    cmd(cw(lacc_pkg::OP_WRITE_REC, 2'h0, lacc_pkg::REC_FILTER), 32'h3, 32'h200);
    cmd(cw(lacc_pkg::OP_START, 2'h2, 8'h0), 32'h0, rej(lacc_pkg::ERR_CHAN));
    wr(lacc_pkg::OFF_CTRL, 32'h1);
    cmd(cw(lacc_pkg::OP_STOP, 2'h1, 8'h0), 32'h0, rej(lacc_pkg::ERR_CHAN));
    wr(lacc_pkg::OFF_CTRL, 32'h3);
    cmd(cw(3'h6, 2'h0, 8'h0), 32'h0, rej(lacc_pkg::ERR_CODE));
    cmd(cw(3'h7, 2'h0, 8'h0), 32'h0, rej(lacc_pkg::ERR_CODE));
    cmd(cw(lacc_pkg::OP_WRITE_REC, 2'h0, lacc_pkg::REC_FILTER), 32'h8, rej(lacc_pkg::ERR_CODE));
    cmd(cw(lacc_pkg::OP_READ_REC, 2'h0, 8'h05), 32'h0, rej(lacc_pkg::ERR_REC));
    cmd(cw(lacc_pkg::OP_WRITE_REC, 2'h0, lacc_pkg::REC_ZERO), 32'h0, rej(lacc_pkg::ERR_REC));
    cmd(cw(lacc_pkg::OP_START, 2'h0, 8'h0), 32'h0, rej(lacc_pkg::ERR_UNADJ));
    cmd(cw(lacc_pkg::OP_WRITE_REC, 2'h0, lacc_pkg::REC_ADJ_WT), 32'h8000_0000, rej(lacc_pkg::ERR_NEG));
    cmd(cw(lacc_pkg::OP_WRITE_REC, 2'h0, lacc_pkg::REC_ADJ_WT), 32'h64, 32'h200);
    cmd(cw(lacc_pkg::OP_ADJ_ZERO, 2'h0, 8'h0), 32'h1000, 32'h200);
    cmd(cw(lacc_pkg::OP_ADJ_WT, 2'h0, 8'h0), 32'h2000, rej(lacc_pkg::ERR_WAIT));
    repeat (25) @(posedge CLOCK);
    cmd(cw(lacc_pkg::OP_ADJ_WT, 2'h0, 8'h0), 32'h10FF, rej(lacc_pkg::ERR_DIST));
    repeat (25) @(posedge CLOCK);
    // The weight point lies far above the zero point.
    cmd(cw(lacc_pkg::OP_ADJ_WT, 2'h0, 8'h0), 32'h2000, 32'h200);
    cmd(cw(lacc_pkg::OP_START, 2'h0, 8'h0), 32'h0, 32'h200);
    cmd(cw(lacc_pkg::OP_START, 2'h1, 8'h0), 32'h0, rej(lacc_pkg::ERR_UNADJ));
    cmd(cw(lacc_pkg::OP_READ_REC, 2'h0, lacc_pkg::REC_WDIG), 32'h0, 32'h200);
    cmd(cw(lacc_pkg::OP_READ_REC, 2'h0, 8'h09), 32'h0, rej(lacc_pkg::ERR_REC));
    rd(lacc_pkg::OFF_RDATA, r);
    chk("rdata kept", r, 32'h2000);
    chk("irq masked", {31'h0, IRQ}, 32'h0);
  endtask

  task automatic close_out();
    if (hung === 1'b1) fails++;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // A bus that never answers ends the run at once instead of waiting out the limit.
  initial begin
    for (int n = 0; n < 20000 && hung !== 1'b1; n++) begin
      @(posedge CLOCK);
    end
    fails++;
    close_out();
  end

  initial begin
    fails = 0;
    total_checks = 0;
    RESET_N = 1'b0;
    LIMIT = 4'h0;
    FAULT = 1'b0;
    repeat (4) @(posedge CLOCK);
    RESET_N <= 1'b1;
    t_reset();
    t_alarm();
    t_cmds();
    close_out();
  end
endmodule // lacc_top_tb
